/* include/ep_resp_pkg.sv */
package ep_resp_pkg;
  // register offsets
  localparam logic [7:0] ADDR_IRQ_EN = 8'h21;
  localparam logic [7:0] ADDR_MODE0 = 8'h30;
  localparam logic [7:0] ADDR_MODE1 = 8'h31;
  localparam logic [7:0] ADDR_MODE2 = 8'h32;
  localparam logic [7:0] ADDR_COUNT0 = 8'h34;
  localparam logic [7:0] ADDR_COUNT1 = 8'h35;
  localparam logic [7:0] ADDR_COUNT2 = 8'h36;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h38;
  // field layout
  localparam int EN_CTRL_BIT = 0;
  localparam int STALL_BIT = 7;
  localparam int NUM_EP = 3;
  localparam logic [2:0] IRQ_EN_RESET = 3'h0;
  // mode codes
  localparam logic [3:0] M_DISABLE = 4'h0;
  localparam logic [3:0] M_NAK_INOUT = 4'h1;
  localparam logic [3:0] M_STATUS_OUT = 4'h2;
  localparam logic [3:0] M_STALL_INOUT = 4'h3;
  localparam logic [3:0] M_IGNORE_INOUT = 4'h4;
  localparam logic [3:0] M_RSVD5 = 4'h5;
  localparam logic [3:0] M_STATUS_IN = 4'h6;
  localparam logic [3:0] M_RSVD7 = 4'h7;
  localparam logic [3:0] M_NAK_OUT = 4'h8;
  localparam logic [3:0] M_ACK_OUT = 4'h9;
  localparam logic [3:0] M_NAKOUT_STIN = 4'ha;
  localparam logic [3:0] M_ACKOUT_NAKIN = 4'hb;
  localparam logic [3:0] M_NAK_IN = 4'hc;
  localparam logic [3:0] M_ACK_IN = 4'hd;
  localparam logic [3:0] M_NAKIN_STOUT = 4'he;
  localparam logic [3:0] M_ACKIN_STOUT = 4'hf;
  // token kinds
  typedef enum logic [1:0] {
    TOK_SETUP = 2'h0,
    TOK_IN = 2'h1,
    TOK_OUT = 2'h2
  } token_t;
  // handshake replies
  typedef enum logic [2:0] {
    RESP_NONE = 3'h0,
    RESP_ACK = 3'h1,
    RESP_NAK = 3'h2,
    RESP_STALL = 3'h3,
    RESP_TX_ZERO = 3'h4,
    RESP_TX_COUNT = 3'h5
  } resp_t;
endpackage : ep_resp_pkg

/* include/ep_event_if.sv */
`timescale 1ns/10ps
`default_nettype none
// per-endpoint transaction events from the core to the decoder, and its replies back
interface ep_event_if;
  import ep_resp_pkg::*;
  logic [3:0] mode;
  logic stall;
  logic tok_valid;
  ep_resp_pkg::token_t tok;
  logic data_zero;
  logic data_tog;
  logic data_ok;
  logic host_ack;
  logic pend_in;
  ep_resp_pkg::resp_t resp;
  logic resp_valid;
  logic set_mode;
  logic [3:0] new_mode;
  logic irq_req;
  modport dec (
    input mode, stall, tok_valid, tok, data_zero, data_tog, data_ok, host_ack,
    output pend_in, resp, resp_valid, set_mode, new_mode, irq_req
  );
  modport core (
    output mode, stall, tok_valid, tok, data_zero, data_tog, data_ok, host_ack,
    input pend_in, resp, resp_valid, set_mode, new_mode, irq_req
  );
endinterface : ep_event_if
`default_nettype wire

/* design/ep_mode_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module ep_mode_decode
  import ep_resp_pkg::*;
#(
  parameter bit IS_CTRL = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // endpoint event carrier
  ep_event_if.dec ev
);
  logic pend_in_q;
  logic [3:0] pend_mode_q;
  logic accept_setup;
  logic chk_ok;
  logic in_tok;
  logic out_tok;
  logic setup_tok;
  resp_t in_r;
  resp_t out_r;

  assign setup_tok = ev.tok_valid && (ev.tok == TOK_SETUP);
  assign in_tok = ev.tok_valid && (ev.tok == TOK_IN);
  assign out_tok = ev.tok_valid && (ev.tok == TOK_OUT);
  // setup accepted by control-style codes
  assign accept_setup = (ev.mode == M_NAK_INOUT) || (ev.mode == M_STATUS_OUT) ||
    (ev.mode == M_STALL_INOUT) || (ev.mode == M_IGNORE_INOUT) ||
    (ev.mode == M_STATUS_IN) || (ev.mode == M_NAKOUT_STIN) ||
    (ev.mode == M_ACKOUT_NAKIN) || (ev.mode == M_NAKIN_STOUT) ||
    (ev.mode == M_ACKIN_STOUT);
  // status check: zero length with toggle one
  assign chk_ok = ev.data_zero && ev.data_tog && ev.data_ok;

  // in-token reply per mode
  always_comb begin
    case (ev.mode)
      M_NAK_INOUT, M_ACKOUT_NAKIN, M_NAK_IN, M_NAKIN_STOUT: in_r = RESP_NAK;
      M_STATUS_OUT, M_STALL_INOUT: in_r = RESP_STALL;
      M_STATUS_IN, M_NAKOUT_STIN: in_r = RESP_TX_ZERO;
      M_ACK_IN: in_r = ev.stall ? RESP_STALL : RESP_TX_COUNT;
      M_ACKIN_STOUT: in_r = RESP_TX_COUNT;
      default: in_r = RESP_NONE;
    endcase
  end

  // out-token reply per mode
  always_comb begin
    case (ev.mode)
      M_NAK_INOUT, M_NAK_OUT, M_NAKOUT_STIN: out_r = RESP_NAK;
      M_STALL_INOUT, M_STATUS_IN: out_r = RESP_STALL;
      M_STATUS_OUT, M_NAKIN_STOUT, M_ACKIN_STOUT:
        out_r = chk_ok ? RESP_ACK : (ev.data_ok ? RESP_STALL : RESP_NONE);
      // a corrupted packet is never acknowledged; its irq is raised further down
      M_ACK_OUT: out_r = ev.stall ? RESP_STALL :
        (ev.data_ok ? RESP_ACK : RESP_NONE);
      M_ACKOUT_NAKIN: out_r = ev.data_ok ? RESP_ACK : RESP_NONE;
      default: out_r = RESP_NONE;
    endcase
  end

  // reply selection
  always_comb begin
    ev.resp = RESP_NONE;
    if (setup_tok && accept_setup && ev.data_ok) begin
      ev.resp = RESP_ACK;
    end else if (in_tok) begin
      ev.resp = in_r;
    end else if (out_tok) begin
      ev.resp = out_r;
    end
  end
  assign ev.resp_valid = ev.tok_valid;

  // mode change and interrupt request, committed together
  always_comb begin
    ev.set_mode = 1'b0;
    ev.new_mode = ev.mode;
    ev.irq_req = 1'b0;
    if (ev.host_ack && pend_in_q) begin
      ev.irq_req = 1'b1;
      if ((pend_mode_q != ev.mode) && (ev.mode != M_DISABLE)) begin
        ev.set_mode = 1'b1;
        ev.new_mode = pend_mode_q;
      end
    end else if (setup_tok && accept_setup) begin
      ev.irq_req = 1'b1;
      if (ev.data_ok && IS_CTRL && (ev.mode != M_DISABLE)) begin
        ev.set_mode = 1'b1;
        ev.new_mode = M_NAK_INOUT;
      end
    end else if (in_tok && ((in_r == RESP_NAK) || (in_r == RESP_STALL))) begin
      ev.irq_req = 1'b1;
    end else if (out_tok && (out_r != RESP_NONE)) begin
      ev.irq_req = 1'b1;
      if (out_r == RESP_ACK && ev.mode == M_ACKOUT_NAKIN) begin
        ev.set_mode = 1'b1;
        ev.new_mode = M_NAK_INOUT;
      end else if (out_r == RESP_ACK && ev.mode == M_ACK_OUT) begin
        ev.set_mode = 1'b1;
        ev.new_mode = M_NAK_OUT;
      end else if (out_r == RESP_ACK) begin
        ev.set_mode = 1'b1;
        ev.new_mode = (ev.mode == M_ACKIN_STOUT) ? M_NAKIN_STOUT : ev.mode;
      end
    end else if (out_tok && (ev.mode == M_ACK_OUT || ev.mode == M_ACKOUT_NAKIN)) begin
      ev.irq_req = 1'b1;
    end
  end

  // remember a data packet sent to in, awaiting host ack
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_in_q <= 1'b0;
      pend_mode_q <= M_DISABLE;
    end else if (in_tok) begin
      pend_in_q <= (in_r == RESP_TX_ZERO) || (in_r == RESP_TX_COUNT);
      pend_mode_q <= (ev.mode == M_ACK_IN) ? M_NAK_IN :
        (ev.mode == M_ACKIN_STOUT) ? M_NAKIN_STOUT : ev.mode;
    end else if (ev.host_ack || ev.tok_valid) begin
      pend_in_q <= 1'b0;
    end
  end
  assign ev.pend_in = pend_in_q;

  ack_in_commit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ev.host_ack && pend_in_q && ev.mode == M_ACK_IN) |-> (ev.set_mode &&
    ev.new_mode == M_NAK_IN && ev.irq_req)) else $error("ack-in commit wrong");
  disabled_quiet_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ev.tok_valid && ev.mode == M_DISABLE) |-> (ev.resp == RESP_NONE && !ev.irq_req))
    else $error("disabled endpoint answered");
  ack_out_stall_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (out_tok && ev.mode == M_ACK_OUT && ev.stall) |-> (ev.resp == RESP_STALL && !ev.set_mode))
    else $error("stall bit ignored");
  status_chk_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (out_tok && ev.mode == M_STATUS_OUT && !ev.data_tog) |-> (ev.resp != RESP_ACK))
    else $error("status check acked toggle zero");
endmodule : ep_mode_decode
`default_nettype wire

/* design/ep_response_top.sv */
`timescale 1ns/10ps
`default_nettype none
module ep_response_top
  import ep_resp_pkg::*;
#(
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // token events from the packet layer
  input wire logic tok_valid,
  input wire logic [1:0] tok_ep,
  input wire logic [1:0] tok_kind,
  input wire logic data_zero,
  input wire logic data_tog,
  input wire logic data_ok,
  input wire logic host_ack,
  // reply to the packet layer
  output logic resp_valid,
  output logic [2:0] resp_code,
  output logic [CNT_W-1:0] resp_len,
  // per-endpoint interrupt requests
  output logic [2:0] ep_irq
);
  logic [3:0] mode_q [NUM_EP];
  logic [NUM_EP-1:0] stall_q;
  logic [CNT_W-1:0] count_q [NUM_EP];
  logic [2:0] irq_en_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_hit;
  logic [1:0] ack_ep_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic [2:0] resp_q;
  logic resp_v_q;
  logic [CNT_W-1:0] len_q;
  logic [NUM_EP-1:0] sel;
  logic [NUM_EP-1:0] ack_sel;
  logic [2:0] ep_resp [NUM_EP];
  logic [NUM_EP-1:0] set_mode_w;
  logic [3:0] new_mode_w [NUM_EP];
  logic [NUM_EP-1:0] req_w;
  logic [NUM_EP-1:0] pend_w;
  logic [NUM_EP-1:0] rv_w;

  // endpoint selection
  assign sel[0] = tok_valid && (tok_ep == 2'h0);
  assign sel[1] = tok_valid && (tok_ep == 2'h1);
  assign sel[2] = tok_valid && (tok_ep == 2'h2);
  // host ack only counts for an endpoint that has data outstanding
  assign ack_sel[0] = host_ack && (ack_ep_q == 2'h0) && pend_w[0];
  assign ack_sel[1] = host_ack && (ack_ep_q == 2'h1) && pend_w[1];
  assign ack_sel[2] = host_ack && (ack_ep_q == 2'h2) && pend_w[2];

  // one decoder per endpoint
  for (genvar g = 0; g < NUM_EP; g++) begin : g_ep
    ep_event_if evi ();
    assign evi.mode = mode_q[g];
    assign evi.stall = (g != 0) ? stall_q[g] : 1'b0;
    assign evi.tok_valid = sel[g];
    assign evi.tok = token_t'(tok_kind);
    assign evi.data_zero = data_zero;
    assign evi.data_tog = data_tog;
    assign evi.data_ok = data_ok;
    assign evi.host_ack = ack_sel[g];
    assign ep_resp[g] = 3'(evi.resp);
    assign set_mode_w[g] = evi.set_mode;
    assign new_mode_w[g] = evi.new_mode;
    assign req_w[g] = evi.irq_req;
    assign pend_w[g] = evi.pend_in;
    assign rv_w[g] = evi.resp_valid;
    ep_mode_decode #(
      .IS_CTRL(g == 0)
    ) u_dec (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .ev(evi)
    );
  end

  // gate requests by enables
  assign irq_hit = req_w & irq_en_q;
  assign ep_irq = irq_stat_q;

  // read mux
  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr == ADDR_IRQ_EN) begin
      rdata_d = {5'h00, irq_en_q};
    end else if (reg_addr == ADDR_MODE0) begin
      rdata_d = {4'h0, mode_q[0]};
    end else if (reg_addr == ADDR_MODE1) begin
      rdata_d = {stall_q[1], 3'h0, mode_q[1]};
    end else if (reg_addr == ADDR_MODE2) begin
      rdata_d = {stall_q[2], 3'h0, mode_q[2]};
    end else if (reg_addr == ADDR_COUNT0) begin
      rdata_d = 8'(count_q[0]);
    end else if (reg_addr == ADDR_COUNT1) begin
      rdata_d = 8'(count_q[1]);
    end else if (reg_addr == ADDR_COUNT2) begin
      rdata_d = 8'(count_q[2]);
    end else if (reg_addr == ADDR_IRQ_STAT) begin
      rdata_d = {5'h00, irq_stat_q};
    end
  end

  // read data one cycle later, only in that cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rdata_d : 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  // enable register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_q <= IRQ_EN_RESET;
    end else if (reg_wr && reg_addr == ADDR_IRQ_EN) begin
      irq_en_q <= reg_wdata[2:0];
    end
  end

  // sticky request flags: set wins over write-one clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_q <= 3'h0;
    end else if (reg_wr && reg_addr == ADDR_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~reg_wdata[2:0]) | irq_hit;
    end else begin
      irq_stat_q <= irq_stat_q | irq_hit;
    end
  end

  // mode, stall and count registers; hardware change wins over write
  for (genvar e = 0; e < NUM_EP; e++) begin : g_reg
    localparam logic [7:0] MA = ADDR_MODE0 + 8'(e);
    localparam logic [7:0] CA = ADDR_COUNT0 + 8'(e);
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        mode_q[e] <= M_DISABLE;
        stall_q[e] <= 1'b0;
      end else if (set_mode_w[e]) begin
        mode_q[e] <= new_mode_w[e];
      end else if (reg_wr && reg_addr == MA) begin
        mode_q[e] <= reg_wdata[3:0];
        stall_q[e] <= reg_wdata[STALL_BIT];
      end
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        count_q[e] <= '0;
      end else if (reg_wr && reg_addr == CA) begin
        count_q[e] <= reg_wdata[CNT_W-1:0];
      end
    end
  end

  // reply register toward the packet layer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resp_v_q <= 1'b0;
      resp_q <= 3'(RESP_NONE);
      len_q <= '0;
      ack_ep_q <= 2'h0;
    end else begin
      resp_v_q <= |rv_w;
      if (|rv_w) begin
        resp_q <= ep_resp[tok_ep];
        len_q <= (ep_resp[tok_ep] == 3'(RESP_TX_COUNT)) ? count_q[tok_ep] : '0;
        ack_ep_q <= tok_ep;
      end
    end
  end
  assign resp_valid = resp_v_q;
  assign resp_code = resp_q;
  assign resp_len = len_q;

  irq_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (req_w[0] && irq_en_q[EN_CTRL_BIT]) |=> irq_stat_q[EN_CTRL_BIT])
    else $error("control irq lost");
  count_len_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sel[1] && ep_resp[1] == 3'(RESP_TX_COUNT)) |=> (resp_len == count_q[1]))
    else $error("payload length wrong");
  disabled_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode_q[2] == M_DISABLE && !(reg_wr && reg_addr == ADDR_MODE2)) |=>
    (mode_q[2] == M_DISABLE)) else $error("disabled mode changed");
  setup_force_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sel[0] && tok_kind == 2'(TOK_SETUP) && data_ok && mode_q[0] == M_STALL_INOUT)
    |=> (mode_q[0] == M_NAK_INOUT && resp_code == 3'(RESP_ACK)))
    else $error("setup did not force nak mode");
endmodule : ep_response_top
`default_nettype wire

/* test/usb_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module usb_host_model
  import ep_resp_pkg::*;
(
  // clock
  input wire logic core_clk,
  // token side
  output logic tok_valid,
  output logic [1:0] tok_ep,
  output logic [1:0] tok_kind,
  output logic data_zero,
  output logic data_tog,
  output logic data_ok,
  output logic host_ack,
  // reply side
  input wire logic resp_valid,
  input wire logic [2:0] resp_code,
  input wire logic [3:0] resp_len
);
  // quiet lines at time zero
  initial begin
    tok_valid = 1'b0;
    tok_ep = 2'h0;
    tok_kind = 2'h0;
    data_zero = 1'b0;
    data_tog = 1'b0;
    data_ok = 1'b0;
    host_ack = 1'b0;
  end

  // one token, its reply, then the host handshake after data sent to us
  task automatic send(input logic [1:0] ep, input logic [1:0] kind, input logic zero,
      input logic tog, input logic ok, input int dly, output logic [2:0] code,
      output logic [3:0] len);
    @(posedge core_clk);
    tok_valid <= 1'b1;
    tok_ep <= ep;
    tok_kind <= kind;
    data_zero <= zero;
    data_tog <= tog;
    data_ok <= ok;
    @(posedge core_clk);
    tok_valid <= 1'b0;
    // released lines flip so a stale value never looks current
    tok_ep <= ~ep;
    tok_kind <= ~kind;
    data_zero <= ~zero;
    data_tog <= ~tog;
    data_ok <= ~ok;
    @(posedge core_clk);
    code = (resp_valid === 1'b1) ? resp_code : 3'h0;
    len = (resp_valid === 1'b1) ? resp_len : 4'h0;
    if (code == RESP_TX_ZERO || code == RESP_TX_COUNT) begin
      repeat (dly) @(posedge core_clk);
      host_ack <= 1'b1;
      @(posedge core_clk);
      host_ack <= 1'b0;
      @(posedge core_clk);
    end
  endtask : send
endmodule : usb_host_model
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ep_resp_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic tok_valid, data_zero, data_tog, data_ok, host_ack, resp_valid;
  logic [1:0] tok_ep, tok_kind;
  logic [2:0] resp_code, ep_irq, rc, e;
  logic [3:0] resp_len, rl;
  logic [7:0] v;
  logic [4:0] m;
  int n_fail = 0;
  int num_checks = 0;
  // replies per code: setup, in, out nibbles
  logic [11:0] tbl [16] = '{12'h000, 12'h122, 12'h131, 12'h133, 12'h100, 12'h000, 12'h143,
    12'h000, 12'h002, 12'h001, 12'h142, 12'h121, 12'h020, 12'h050, 12'h121, 12'h151};
  logic [3:0] cnt [3] = '{4'h3, 4'hf, 4'h0};

  always #20 core_clk = ~core_clk;

  ep_response_top #(.CNT_W(4)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_kind(tok_kind),
    .data_zero(data_zero), .data_tog(data_tog), .data_ok(data_ok), .host_ack(host_ack),
    .resp_valid(resp_valid), .resp_code(resp_code), .resp_len(resp_len), .ep_irq(ep_irq));

  usb_host_model host (.core_clk(core_clk), .tok_valid(tok_valid), .tok_ep(tok_ep),
    .tok_kind(tok_kind), .data_zero(data_zero), .data_tog(data_tog), .data_ok(data_ok),
    .host_ack(host_ack), .resp_valid(resp_valid), .resp_code(resp_code),
    .resp_len(resp_len));

  // register port cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : rd

  // comparisons
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] x);
    num_checks++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR %0t register got %h expected %h", $time, g, x);
    end
  endtask : chk_reg

  task automatic chk_resp(input logic [2:0] g, input logic [3:0] gl, input logic [2:0] x,
      input logic [3:0] xl);
    num_checks++;
    if (g !== x || gl !== xl) begin
      n_fail++;
      $display("ERROR %0t reply got %h/%h expected %h/%h", $time, g, gl, x, xl);
    end
  endtask : chk_resp

  task automatic chk_irq(input logic [2:0] g, input logic [2:0] x);
    num_checks++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR %0t irq got %b expected %b", $time, g, x);
    end
  endtask : chk_irq

  task automatic wrap_up();
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // mode expected after a token, bit 4 set where it is not checked
  function automatic logic [4:0] nxt(input int ep, input int code, input int k,
      input logic [2:0] x);
    logic [4:0] r;
    r = {1'b0, code[3:0]};
    if (k == 0 && x != 3'h0) r = (ep == 0) ? 5'h01 : 5'h10;
    if (k == 2 && x == 3'h1 && code == 11) r = 5'h01;
    if (k == 2 && x == 3'h1 && code == 9) r = 5'h08;
    if (k == 2 && x == 3'h1 && code == 15) r = 5'h0e;
    if (k == 1 && code == 13) r = 5'h0c;
    if (k == 1 && code == 15) r = 5'h0e;
    return r;
  endfunction : nxt

  // watchdog
  initial begin
    repeat (30000) @(posedge core_clk);
    n_fail++;
    wrap_up();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    chk_irq(ep_irq, 3'h0);
    rd(ADDR_IRQ_EN, v);
    chk_reg(v, 8'h00);
    for (int i = 0; i < 3; i++) begin
      rd(8'(ADDR_MODE0 + i), v);
      chk_reg(v, 8'h00);
      wr(8'(ADDR_COUNT0 + i), {4'h0, cnt[i]});
    end
    wr(ADDR_IRQ_EN, 8'hff);
    rd(ADDR_IRQ_EN, v);
    chk_reg(v, 8'h07);
    rd(8'h3f, v);
    chk_reg(v, 8'h00);
    // every code, every token kind, every endpoint
    for (int ep = 0; ep < 3; ep++) begin
      for (int code = 0; code < 16; code++) begin
        for (int k = 0; k < 3; k++) begin
          wr(8'(ADDR_MODE0 + ep), 8'(code));
          wr(ADDR_IRQ_STAT, 8'h07);
          host.send(2'(ep), 2'(k), k == 2, k == 2, 1'b1, 0, rc, rl);
          e = tbl[code][4*(2-k) +: 3];
          chk_resp(rc, rl, e, (e == 3'h5) ? cnt[ep] : 4'h0);
          chk_irq(ep_irq, (e != 3'h0) ? 3'(1 << ep) : 3'h0);
          m = nxt(ep, code, k, e);
          if (!m[4]) begin
            rd(8'(ADDR_MODE0 + ep), v);
            chk_reg({4'h0, v[3:0]}, {4'h0, m[3:0]});
          end
        end
      end
    end
    // enable bit mapping, reserved bit 3 enables nothing
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_IRQ_EN, 8'(1 << b));
      wr(ADDR_IRQ_STAT, 8'h07);
      for (int x = 0; x < 3; x++) begin
        wr(8'(ADDR_MODE0 + x), 8'h01);
        host.send(2'(x), TOK_OUT, 1'b0, 1'b0, 1'b1, 0, rc, rl);
      end
      chk_irq(ep_irq, 3'(1 << b));
    end
    wr(ADDR_IRQ_EN, 8'h07);
    // stall selector on data endpoints only
    wr(ADDR_MODE1, 8'h89);
    host.send(2'h1, TOK_OUT, 1'b1, 1'b1, 1'b1, 0, rc, rl);
    chk_resp(rc, rl, RESP_STALL, 4'h0);
    wr(ADDR_MODE2, 8'h8d);
    host.send(2'h2, TOK_IN, 1'b0, 1'b0, 1'b1, 0, rc, rl);
    chk_resp(rc, rl, RESP_STALL, 4'h0);
    rd(ADDR_MODE2, v);
    chk_reg(v, 8'h8d);
    // status check with a bad length, toggle or crc
    for (int j = 0; j < 3; j++) begin
      wr(ADDR_MODE0, 8'h02);
      host.send(2'h0, TOK_OUT, j != 0, j != 1, j != 2, 0, rc, rl);
      chk_resp(rc, rl, (j == 2) ? RESP_NONE : RESP_STALL, 4'h0);
    end
    // ack-out modes raise irq on bad crc without a reply
    wr(ADDR_MODE1, 8'h09);
    wr(ADDR_MODE0, 8'h0b);
    wr(ADDR_IRQ_STAT, 8'h07);
    host.send(2'h1, TOK_OUT, 1'b0, 1'b0, 1'b0, 0, rc, rl);
    chk_resp(rc, rl, RESP_NONE, 4'h0);
    host.send(2'h0, TOK_OUT, 1'b0, 1'b0, 1'b0, 0, rc, rl);
    chk_irq(ep_irq, 3'h3);
    rd(ADDR_MODE1, v);
    chk_reg(v, 8'h09);
    // slow host handshake and an unused endpoint number
    wr(ADDR_MODE2, 8'h0d);
    wr(ADDR_IRQ_STAT, 8'h07);
    host.send(2'h3, TOK_IN, 1'b0, 1'b0, 1'b1, 0, rc, rl);
    chk_resp(rc, rl, RESP_NONE, 4'h0);
    host.send(2'h2, TOK_IN, 1'b0, 1'b0, 1'b1, 5, rc, rl);
    chk_irq(ep_irq, 3'h4);
    rd(ADDR_MODE2, v);
    chk_reg(v, 8'h0c);
    wr(ADDR_IRQ_STAT, 8'h07);
    rd(ADDR_IRQ_STAT, v);
    chk_reg(v, 8'h00);
    // second reset in mid-run
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(ADDR_MODE1, v);
    chk_reg(v, 8'h00);
    rd(ADDR_IRQ_EN, v);
    chk_reg(v, 8'h00);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
